/* File: design/scl_strap_latch.sv */
// Strap configuration latch: capture, decode and register access
// Function
// - Every strap is sampled once when the chip reset is released and becomes the configuration.
// - GMII/MII for 0001, 1001, 1011 without 1000 half; wake on LED for 1001, interrupt for 1011.
// - Code 0100 is NAND tree test, 0111 is power-down, every other code is reserved.
// - The management address is the three address straps in bits 2:0 with bits 4:3 zero.
// - An address strap held high reads as one and held low as zero.
// - The address-zero enable defaults to the inverse of its strap level.
// - With address-zero enable set, requests to address 0 are accepted besides the own address.
// - A low address-zero strap answers address 0 too, a high strap answers only the own address.
// - The reference clock is driven out only when its enable strap was captured high.
// - The reference clock defaults to the local clock and may be switched to the recovered clock.
// - An LED style strap of one selects individual LEDs, zero selects tri-colour LEDs.
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

module scl_strap_latch (
  input wire logic sys_clk, // System clock, 25 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic chip_rst_n, // Chip reset pin, active low
  input wire logic [3:0] mode_strap, // Device mode straps
  input wire logic [2:0] mgmt_addr_strap, // Management address straps
  input wire logic addr_zero_strap, // Address-zero strap
  input wire logic refclk_out_strap, // Clock-output enable strap
  input wire logic led_style_strap, // LED style strap
  input wire logic clk125_local, // Local 125 MHz clock
  input wire logic clk125_rx, // Recovered receive clock
  input wire logic [4:0] mgmt_req_addr, // Address of a management request
  output logic mgmt_addr_hit, // Request is for this device
  output logic [4:0] mgmt_addr, // Full management address
  output logic addr_zero_enable, // Answer address zero too
  output logic [1:0] dev_mode, // Decoded device mode
  output logic [3:0] an_adv, // Advertisement defaults
  output logic wake_event_out_a_en, // Wake events on indicator_out_a
  output logic wake_event_out_b_en, // Wake events on the interrupt pin
  output logic led_individual, // 1 individual, 0 tri-colour
  output logic refclk_out_pin, // Reference clock output
  output logic refclk_out_oe_n, // Low while refclk_out_pin drives
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [3:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o // Wishbone acknowledge
);

  scl_strap_if img ();

  scl_strap_sampler scl_strap_sampler_i (
    .sys_clk(sys_clk),
    .srst(srst),
    .chip_rst_n(chip_rst_n),
    .mode_strap(mode_strap),
    .mgmt_addr_strap(mgmt_addr_strap),
    .addr_zero_strap(addr_zero_strap),
    .refclk_out_strap(refclk_out_strap),
    .led_style_strap(led_style_strap),
    .img(img)
  );

  function automatic scl_pkg::scl_mode_e decode_mode(input logic [3:0] code);
    scl_pkg::scl_mode_e m;
    m = scl_pkg::SCL_MODE_RSVD;
    if (code == scl_pkg::SCL_CODE_GMII || code == scl_pkg::SCL_CODE_GMII_WAKE_A ||
        code == scl_pkg::SCL_CODE_GMII_WAKE_B) begin
      m = scl_pkg::SCL_MODE_GMII;
    end else if (code == scl_pkg::SCL_CODE_NAND) begin
      m = scl_pkg::SCL_MODE_NAND;
    end else if (code == scl_pkg::SCL_CODE_PDOWN) begin
      m = scl_pkg::SCL_MODE_PDOWN;
    end
    return m;
  endfunction

  // Decoded configuration, registered
  scl_pkg::scl_mode_e mode_q, mode_d;
  logic [3:0] adv_q, adv_d;
  logic wake_a_q, wake_a_d;
  logic wake_b_q, wake_b_d;
  logic [4:0] addr_q, addr_d;
  logic led_q, led_d;
  logic refclk_en_q, refclk_en_d;
  // Software-writable control
  logic zero_en_q, zero_en_d;
  logic refclk_src_q, refclk_src_d;
  // Bus slave
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic wb_req;
  logic ctrl_wr;
  logic [31:0] strap_word, cfg_word, ctrl_word, stat_word;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign ctrl_wr = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == scl_pkg::SCL_OFS_CTRL);

  always_comb begin
    mode_d = decode_mode(img.mode);
    adv_d = (mode_d == scl_pkg::SCL_MODE_GMII) ? scl_pkg::SCL_ADV_GMII :
      scl_pkg::SCL_ADV_NONE;
    wake_a_d = (img.mode == scl_pkg::SCL_CODE_GMII_WAKE_A);
    wake_b_d = (img.mode == scl_pkg::SCL_CODE_GMII_WAKE_B);
    addr_d = {2'b00, img.addr};
    led_d = img.led_style;
    refclk_en_d = img.refclk_en;
    zero_en_d = zero_en_q;
    refclk_src_d = refclk_src_q;
    if (ctrl_wr) begin
      zero_en_d = wb_dat_i[scl_pkg::SCL_CTRL_ZERO_EN_BIT];
      refclk_src_d = wb_dat_i[scl_pkg::SCL_CTRL_REFCLK_SRC_BIT];
    end
    // Capture reload wins over a software write in the same cycle
    // Raw strap, since the captured image only updates on this edge
    if (img.capture) begin
      zero_en_d = ~addr_zero_strap;
      refclk_src_d = scl_pkg::SCL_RST_REFCLK_SRC;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_q <= scl_pkg::SCL_MODE_RSVD;
      adv_q <= scl_pkg::SCL_ADV_NONE;
      wake_a_q <= 1'b0;
      wake_b_q <= 1'b0;
      addr_q <= 5'h00;
      led_q <= scl_pkg::SCL_RST_LED;
      refclk_en_q <= scl_pkg::SCL_RST_REFCLK;
      zero_en_q <= ~scl_pkg::SCL_RST_ZERO;
      refclk_src_q <= scl_pkg::SCL_RST_REFCLK_SRC;
    end else begin
      mode_q <= mode_d;
      adv_q <= adv_d;
      wake_a_q <= wake_a_d;
      wake_b_q <= wake_b_d;
      addr_q <= addr_d;
      led_q <= led_d;
      refclk_en_q <= refclk_en_d;
      zero_en_q <= zero_en_d;
      refclk_src_q <= refclk_src_d;
    end
  end

  // Register images
  always_comb begin
    strap_word = 32'h0000_0000;
    strap_word[scl_pkg::SCL_STRAP_MODE_LSB +: 4] = img.mode;
    strap_word[scl_pkg::SCL_STRAP_ADDR_LSB +: 3] = img.addr;
    strap_word[scl_pkg::SCL_STRAP_ZERO_BIT] = img.addr_zero;
    strap_word[scl_pkg::SCL_STRAP_REFCLK_BIT] = img.refclk_en;
    strap_word[scl_pkg::SCL_STRAP_LED_BIT] = img.led_style;
    cfg_word = 32'h0000_0000;
    cfg_word[scl_pkg::SCL_CFG_MODE_LSB +: 2] = mode_q;
    cfg_word[scl_pkg::SCL_CFG_WAKE_A_BIT] = wake_a_q;
    cfg_word[scl_pkg::SCL_CFG_WAKE_B_BIT] = wake_b_q;
    cfg_word[scl_pkg::SCL_CFG_ADV_LSB +: 4] = adv_q;
    cfg_word[scl_pkg::SCL_CFG_ADDR_LSB +: 5] = addr_q;
    cfg_word[scl_pkg::SCL_CFG_REFCLK_EN_BIT] = refclk_en_q;
    cfg_word[scl_pkg::SCL_CFG_LED_BIT] = led_q;
    ctrl_word = 32'h0000_0000;
    ctrl_word[scl_pkg::SCL_CTRL_ZERO_EN_BIT] = zero_en_q;
    ctrl_word[scl_pkg::SCL_CTRL_REFCLK_SRC_BIT] = refclk_src_q;
    stat_word = 32'h0000_0000;
    stat_word[scl_pkg::SCL_STAT_VALID_BIT] = img.valid;
    stat_word[scl_pkg::SCL_STAT_HOLD_BIT] = ~chip_rst_n;
  end

  // Wishbone slave: one wait state, unmapped reads return zero
  always_comb begin
    ack_d = wb_req;
    rdat_d = rdat_q;
    if (wb_req && !wb_we_i) begin
      if (wb_adr_i == scl_pkg::SCL_OFS_STRAP) begin
        rdat_d = strap_word;
      end else if (wb_adr_i == scl_pkg::SCL_OFS_CONFIG) begin
        rdat_d = cfg_word;
      end else if (wb_adr_i == scl_pkg::SCL_OFS_CTRL) begin
        rdat_d = ctrl_word;
      end else if (wb_adr_i == scl_pkg::SCL_OFS_STATUS) begin
        rdat_d = stat_word;
      end else begin
        rdat_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Management address match
  assign mgmt_addr_hit = (mgmt_req_addr == addr_q) |
    (zero_en_q & (mgmt_req_addr == 5'h00));

  // Reference clock path, gated by the captured enable
  assign refclk_out_pin = refclk_en_q & (refclk_src_q ? clk125_rx : clk125_local);
  assign refclk_out_oe_n = ~refclk_en_q;

  assign mgmt_addr = addr_q;
  assign addr_zero_enable = zero_en_q;
  assign dev_mode = mode_q;
  assign an_adv = adv_q;
  assign wake_event_out_a_en = wake_a_q;
  assign wake_event_out_b_en = wake_b_q;
  assign led_individual = led_q;

endmodule

`default_nettype wire

/* File: design/scl_pkg.sv */
// Shared constants and types for the strap configuration latch
package scl_pkg;

  // Register byte offsets
  localparam logic [3:0] SCL_OFS_STRAP = 4'h0;
  localparam logic [3:0] SCL_OFS_CONFIG = 4'h4;
  localparam logic [3:0] SCL_OFS_CTRL = 4'h8;
  localparam logic [3:0] SCL_OFS_STATUS = 4'hc;

  // Strap register field positions
  localparam int SCL_STRAP_MODE_LSB = 0;
  localparam int SCL_STRAP_ADDR_LSB = 4;
  localparam int SCL_STRAP_ZERO_BIT = 7;
  localparam int SCL_STRAP_REFCLK_BIT = 8;
  localparam int SCL_STRAP_LED_BIT = 9;

  // Config register field positions
  localparam int SCL_CFG_MODE_LSB = 0;
  localparam int SCL_CFG_WAKE_A_BIT = 2;
  localparam int SCL_CFG_WAKE_B_BIT = 3;
  localparam int SCL_CFG_ADV_LSB = 4;
  localparam int SCL_CFG_ADDR_LSB = 8;
  localparam int SCL_CFG_REFCLK_EN_BIT = 13;
  localparam int SCL_CFG_LED_BIT = 14;

  // Control register field positions
  localparam int SCL_CTRL_ZERO_EN_BIT = 0;
  localparam int SCL_CTRL_REFCLK_SRC_BIT = 1;

  // Status register field positions
  localparam int SCL_STAT_VALID_BIT = 0;
  localparam int SCL_STAT_HOLD_BIT = 1;

  // Mode strap codes
  localparam logic [3:0] SCL_CODE_GMII = 4'h1;
  localparam logic [3:0] SCL_CODE_GMII_WAKE_A = 4'h9;
  localparam logic [3:0] SCL_CODE_GMII_WAKE_B = 4'hb;
  localparam logic [3:0] SCL_CODE_NAND = 4'h4;
  localparam logic [3:0] SCL_CODE_PDOWN = 4'h7;

  // Advertisement {1000 full, 1000 half, 10/100 full, 10/100 half}
  localparam logic [3:0] SCL_ADV_GMII = 4'hb;
  localparam logic [3:0] SCL_ADV_NONE = 4'h0;

  // Reset values of the captured strap image and of the reference clock source control
  localparam logic [3:0] SCL_RST_MODE = 4'h0;
  localparam logic [2:0] SCL_RST_ADDR = 3'h0;
  localparam logic SCL_RST_ZERO = 1'b1;
  localparam logic SCL_RST_REFCLK = 1'b0;
  localparam logic SCL_RST_LED = 1'b0;
  localparam logic SCL_RST_REFCLK_SRC = 1'b0;

  localparam int SCL_MGMT_ADDR_W = 5;

  typedef enum logic [1:0] {
    SCL_MODE_RSVD,
    SCL_MODE_GMII,
    SCL_MODE_NAND,
    SCL_MODE_PDOWN
  } scl_mode_e;

endpackage

/* File: design/scl_strap_if.sv */
// Captured strap image passed from the sampler to the decoder
`timescale 1ns/100ps
`default_nettype none

interface scl_strap_if;
  logic [3:0] mode;
  logic [2:0] addr;
  logic addr_zero;
  logic refclk_en;
  logic led_style;
  logic valid;
  logic capture;

  modport cap (output mode, addr, addr_zero, refclk_en, led_style, valid, capture);
  modport use_side (input mode, addr, addr_zero, refclk_en, led_style, valid, capture);
endinterface

`default_nettype wire

/* File: design/scl_strap_sampler.sv */
// Samples strap levels on the rising edge of the chip reset
`timescale 1ns/100ps
`default_nettype none

module scl_strap_sampler (
  input wire logic sys_clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic chip_rst_n, // Chip reset pin level
  input wire logic [3:0] mode_strap, // Device mode straps
  input wire logic [2:0] mgmt_addr_strap, // Address straps
  input wire logic addr_zero_strap, // Address-zero strap
  input wire logic refclk_out_strap, // Clock-output enable strap
  input wire logic led_style_strap, // LED style strap
  scl_strap_if.cap img // Captured image
);

  logic rst_n_prev_q, rst_n_prev_d;
  logic [3:0] mode_q, mode_d;
  logic [2:0] addr_q, addr_d;
  logic zero_q, zero_d;
  logic refclk_q, refclk_d;
  logic led_q, led_d;
  logic valid_q, valid_d;
  logic release_edge;

  assign release_edge = chip_rst_n & ~rst_n_prev_q;

  always_comb begin
    rst_n_prev_d = chip_rst_n;
    mode_d = mode_q;
    addr_d = addr_q;
    zero_d = zero_q;
    refclk_d = refclk_q;
    led_d = led_q;
    valid_d = valid_q;
    if (release_edge) begin
      mode_d = mode_strap;
      addr_d = mgmt_addr_strap;
      zero_d = addr_zero_strap;
      refclk_d = refclk_out_strap;
      led_d = led_style_strap;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rst_n_prev_q <= 1'b0;
      mode_q <= scl_pkg::SCL_RST_MODE;
      addr_q <= scl_pkg::SCL_RST_ADDR;
      zero_q <= scl_pkg::SCL_RST_ZERO;
      refclk_q <= scl_pkg::SCL_RST_REFCLK;
      led_q <= scl_pkg::SCL_RST_LED;
      valid_q <= 1'b0;
    end else begin
      rst_n_prev_q <= rst_n_prev_d;
      mode_q <= mode_d;
      addr_q <= addr_d;
      zero_q <= zero_d;
      refclk_q <= refclk_d;
      led_q <= led_d;
      valid_q <= valid_d;
    end
  end

  assign img.mode = mode_q;
  assign img.addr = addr_q;
  assign img.addr_zero = zero_q;
  assign img.refclk_en = refclk_q;
  assign img.led_style = led_q;
  assign img.valid = valid_q;
  assign img.capture = release_edge;

endmodule

`default_nettype wire

/* File: verif/scl_strap_latch_checker.sv */
// Concurrent property checker for the strap configuration latch
`timescale 1ns/100ps
`default_nettype none

module scl_strap_latch_checker (
  input wire logic sys_clk, // Clock
  input wire logic srst, // Reset
  input wire logic chip_rst_n, // Chip reset
  input wire logic [3:0] mode_strap, // Mode straps
  input wire logic [2:0] mgmt_addr_strap, // Address straps
  input wire logic addr_zero_strap, // Zero strap
  input wire logic refclk_out_strap, // Clock strap
  input wire logic led_style_strap, // LED strap
  input wire logic [4:0] mgmt_req_addr, // Request address
  input wire logic mgmt_addr_hit, // Hit
  input wire logic [4:0] mgmt_addr, // Address
  input wire logic addr_zero_enable, // Zero enable
  input wire logic [1:0] dev_mode, // Mode
  input wire logic [3:0] an_adv, // Advertisement
  input wire logic wake_event_out_a_en, // Wake a
  input wire logic wake_event_out_b_en, // Wake b
  input wire logic led_individual, // LED style
  input wire logic refclk_out_pin, // Clock out
  input wire logic refclk_out_oe_n // Clock enable
);
  logic chip_q, chip_d, cap;
  logic [1:0] age_q, age_d;

  // Capture edge, mirrored from the chip reset level
  assign cap = chip_rst_n & ~chip_q;

  always_comb begin
    chip_d = srst ? 1'b0 : chip_rst_n;
    age_d = (srst | cap) ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
  end

  always_ff @(posedge sys_clk) begin
    chip_q <= chip_d;
    age_q <= age_d;
  end

  function automatic logic [1:0] mode_of(input logic [3:0] c);
    case (c)
      4'h1, 4'h9, 4'hb: return 2'h1;
      4'h4: return 2'h2;
      4'h7: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_addr; cap |-> ##2 mgmt_addr == {2'h0, $past(mgmt_addr_strap, 2)}; endproperty
  a_addr: assert property (p_addr) else $error("management address wrong");
  property p_zero; cap |=> addr_zero_enable == !$past(addr_zero_strap); endproperty
  a_zero: assert property (p_zero) else $error("zero enable wrong");
  property p_hit;
    mgmt_addr_hit == (mgmt_req_addr == mgmt_addr || addr_zero_enable && mgmt_req_addr == 5'h0);
  endproperty
  a_hit: assert property (p_hit) else $error("address match wrong");
  property p_mode; cap |-> ##2 dev_mode == mode_of($past(mode_strap, 2)); endproperty
  a_mode: assert property (p_mode) else $error("device mode wrong");
  property p_adv;
    cap |-> ##2 an_adv == (mode_of($past(mode_strap, 2)) == 2'h1 ? 4'hb : 4'h0)
      && wake_event_out_a_en == ($past(mode_strap, 2) == 4'h9)
      && wake_event_out_b_en == ($past(mode_strap, 2) == 4'hb);
  endproperty
  a_adv: assert property (p_adv) else $error("advertisement or wake wrong");
  property p_led; cap |-> ##2 led_individual == $past(led_style_strap, 2); endproperty
  a_led: assert property (p_led) else $error("LED style wrong");
  property p_oe; cap |-> ##2 refclk_out_oe_n == !$past(refclk_out_strap, 2); endproperty
  a_oe: assert property (p_oe) else $error("clock enable wrong");
  property p_off; refclk_out_oe_n |-> !refclk_out_pin; endproperty
  a_off: assert property (p_off) else $error("clock driven while off");
  property p_hold;
    age_q == 2'h3 |-> $stable(mgmt_addr) && $stable(dev_mode) && $stable(an_adv)
      && $stable(led_individual) && $stable(refclk_out_oe_n);
  endproperty
  a_hold: assert property (p_hold) else $error("configuration moved");
endmodule

bind scl_strap_latch scl_strap_latch_checker scl_strap_latch_checker_i (.sys_clk, .srst,
  .chip_rst_n, .mode_strap, .mgmt_addr_strap, .addr_zero_strap, .refclk_out_strap,
  .led_style_strap, .mgmt_req_addr, .mgmt_addr_hit, .mgmt_addr, .addr_zero_enable,
  .dev_mode, .an_adv, .wake_event_out_a_en, .wake_event_out_b_en, .led_individual,
  .refclk_out_pin, .refclk_out_oe_n);

`default_nettype wire

/* File: verif/scl_strap_board.sv */
// Board strap resistors: static levels seen by the strap pins
`timescale 1ns/100ps
`default_nettype none

module scl_strap_board (
  output logic [3:0] mode_strap, // Mode pulls
  output logic [2:0] mgmt_addr_strap, // Address pulls
  output logic addr_zero_strap, // Zero pull
  output logic refclk_out_strap, // Clock pull
  output logic led_style_strap // LED pull
);
  logic [9:0] pulls = 10'h0;

  assign {led_style_strap, refclk_out_strap, addr_zero_strap, mgmt_addr_strap, mode_strap} = pulls;

  // Refit the resistors
  task automatic set(input logic [9:0] v);
    pulls <= v;
  endtask
endmodule

`default_nettype wire

/* File: verif/strap_config_latch_bench.sv */
// Self-checking bench for the strap configuration latch
`timescale 1ns/100ps
`default_nettype none

module strap_config_latch_bench;
  logic sys_clk = 0, srst = 1, chip_rst_n = 0, loc = 1, rx = 0, cyc = 0, stb = 0, we = 0;
  logic [3:0] adr = 4'h0, sel = 4'hf, mode_s, adv;
  logic [31:0] wd = 32'h0, rd, q;
  logic [4:0] req = 5'h0, ma;
  logic [2:0] addr_s;
  logic [1:0] dm;
  logic zs, rs, ls, hit, aze, wa, wb, led, pin, oen, ack;
  int n_errors = 0, checked = 0;

  scl_strap_board scl_strap_board_i (.mode_strap(mode_s), .mgmt_addr_strap(addr_s),
    .addr_zero_strap(zs), .refclk_out_strap(rs), .led_style_strap(ls));
  scl_strap_latch scl_strap_latch_i (.sys_clk, .srst, .chip_rst_n, .mode_strap(mode_s),
    .mgmt_addr_strap(addr_s), .addr_zero_strap(zs), .refclk_out_strap(rs),
    .led_style_strap(ls), .clk125_local(loc), .clk125_rx(rx), .mgmt_req_addr(req),
    .mgmt_addr_hit(hit), .mgmt_addr(ma), .addr_zero_enable(aze), .dev_mode(dm),
    .an_adv(adv), .wake_event_out_a_en(wa), .wake_event_out_b_en(wb),
    .led_individual(led), .refclk_out_pin(pin), .refclk_out_oe_n(oen), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  // Reset pulse with new strap levels, then wait out the decode
  task automatic strap(input logic [9:0] v);
    chip_rst_n <= 1'b0;
    scl_strap_board_i.set(v);
    repeat (2) @(posedge sys_clk);
    chip_rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    logic [9:0] v;
    logic [3:0] c;
    logic [1:0] em;
    logic [31:0] cfg;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      v = {c[2], c[1], c[0], ~c[2:0], c};
      strap(v);
      em = (c == 4'h1 || c == 4'h9 || c == 4'hb) ? 2'h1 :
        c == 4'h4 ? 2'h2 : c == 4'h7 ? 2'h3 : 2'h0;
      cfg = {17'h0, c[2], c[1], 2'h0, ~c[2:0], em == 2'h1 ? 4'hb : 4'h0,
        c == 4'hb, c == 4'h9, em};
      rd_chk(scl_pkg::SCL_OFS_CONFIG, cfg);
      chk({adv, wb, wa, dm}, cfg[7:0]);
      chk({led, ~oen, ma}, cfg[14:8]);
      chk(aze, {~c[0]});
      chk(pin, c[1]);
      req <= 5'h0;
      @(posedge sys_clk);
      chk(hit, {~c[0] | (c[2:0] == 3'h7)});
      req <= {2'h0, ~c[2:0]};
      @(posedge sys_clk);
      chk(hit, 1'b1);
      req <= 5'h1f;
      @(posedge sys_clk);
      chk(hit, 1'b0);
    end
    $display("test strap decode done");
    scl_strap_board_i.set(~v);
    repeat (4) @(posedge sys_clk);
    rd_chk(scl_pkg::SCL_OFS_STRAP, {22'h0, v});
    rd_chk(scl_pkg::SCL_OFS_CONFIG, cfg);
    rd_chk(scl_pkg::SCL_OFS_STATUS, 32'h1);
    $display("test strap hold done");
    xfer(1'b1, scl_pkg::SCL_OFS_CTRL, 32'h3);
    chk({aze, pin}, 2'b10);
    rx <= 1'b1;
    loc <= 1'b0;
    @(posedge sys_clk);
    chk(pin, 1'b1);
    rd_chk(scl_pkg::SCL_OFS_CTRL, 32'h3);
    rd_chk(4'h3, 32'h0);
    chip_rst_n <= 1'b0;
    rd_chk(scl_pkg::SCL_OFS_STATUS, 32'h3);
    strap(v);
    chk({aze, pin}, 2'b00);
    $display("test clock source done");
    report_and_stop();
  end
endmodule

`default_nettype wire
